// File: pkg/sep_pkg.sv
package sep_pkg;

    localparam int MEM_AW = 8;
    localparam int SYNC_STAGES = 2;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam int SEL_RW_POS = 0;
    localparam int SEL_CE_LSB = 1;
    localparam int SEL_CE_MSB = 3;
    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_TYPE_MSB = 7;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] SHIFT_RESET = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEVSEL,
        ST_DEVACK,
        ST_ADDR,
        ST_ADDRACK,
        ST_WAIT,
        ST_RDATA,
        ST_MACK,
        ST_NEXT
    } sep_state_e;

endpackage

// File: src/sep_ee_core.sv
`timescale 1ns/1ns
module sep_ee_core
    import sep_pkg::*;
#(
    parameter int ADDR_W = MEM_AW,
    // Arbitrary value; device type field of the select byte
    parameter logic [3:0] DEV_TYPE = 4'h5
)
(
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire logic chip_sel_pin_0,
    input wire logic chip_sel_pin_1,
    input wire logic chip_sel_pin_2,
    input wire logic write_protect_in,
    input wire logic prog_busy_in,
    input wire logic mem_wr_en_in,
    input wire logic [ADDR_W-1:0] mem_wr_addr_in,
    input wire logic [7:0] mem_wr_data_in,
    output logic standby_out,
    output logic [ADDR_W-1:0] addr_out
);

    logic [4:0] pins_s;
    logic scl_d_reg;
    logic sda_d_reg;
    sep_state_e state_reg;
    sep_state_e state_next;
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic sda_oe_n_reg;
    logic sda_oe_n_next;
    logic standby_reg;
    logic standby_next;
    logic rw_reg;
    logic rw_next;
    logic sda_lo_reg;
    logic [7:0] mem [0:(2**ADDR_W)-1];

    sep_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .clk_in(sys_clk_in),
        .srst_in(srst_in),
        .d_in({scl_in, sda_in, chip_sel_pin_2, chip_sel_pin_1, chip_sel_pin_0}),
        .q_out(pins_s)
    );

    wire scl_s;
    wire sda_s;
    wire [2:0] ce_s;
    wire scl_rise;
    wire scl_fall;
    wire start_evt;
    wire stop_evt;
    wire last_bit;
    wire [7:0] rx_byte;
    wire [ADDR_W-1:0] rx_addr;
    wire type_ok;
    wire ce_ok;
    wire sel_match;
    wire in_read;
    wire [7:0] rd_byte;
    wire [ADDR_W-1:0] addr_inc;
    wire [ADDR_W-1:0] addr_top;

    assign scl_s = pins_s[4];
    assign sda_s = pins_s[3];
    assign ce_s = pins_s[2:0];
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    // Data edges while the clock stays high frame a transfer
    assign start_evt = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_evt = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign last_bit = (bit_cnt_reg == LAST_BIT);
    assign rx_byte = {shift_reg[6:0], sda_s};
    assign rx_addr = rx_byte[ADDR_W-1:0];
    assign type_ok = (rx_byte[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE);
    assign ce_ok = (rx_byte[SEL_CE_MSB:SEL_CE_LSB] == ce_s);
    assign sel_match = type_ok & ce_ok;
    assign in_read = (state_reg == ST_RDATA) || (state_reg == ST_MACK) || (state_reg == ST_NEXT);
    // read path
    // The read path never consults the write protect level
    assign rd_byte = mem[addr_reg];
    // counter wrap
    // Natural overflow of the counter returns it to location zero
    assign addr_inc = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
    assign addr_top = '1;

    // Array contents come from the write engine
    always_ff @(posedge sys_clk_in)
    begin
        if (mem_wr_en_in)
        begin
            mem[mem_wr_addr_in] <= mem_wr_data_in;
        end
    end

    always_comb
    begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        addr_next = addr_reg;
        sda_oe_n_next = sda_oe_n_reg;
        standby_next = standby_reg;
        rw_next = rw_reg;
        if (start_evt && !prog_busy_in)
        begin
            state_next = ST_DEVSEL;
            bit_cnt_next = BIT_CNT_RESET;
            sda_oe_n_next = 1'b1;
            standby_next = 1'b0;
        end
        else if (stop_evt && !in_read)
        begin
            state_next = ST_IDLE;
            sda_oe_n_next = 1'b1;
            standby_next = 1'b1;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    sda_oe_n_next = 1'b1;
                end
                ST_DEVSEL:
                begin
                    if (scl_rise)
                    begin
                        shift_next = rx_byte;
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                        if (last_bit)
                        begin
                            if (sel_match && !prog_busy_in)
                            begin
                                state_next = ST_DEVACK;
                                rw_next = rx_byte[SEL_RW_POS];
                            end
                            else
                            begin
                                state_next = ST_IDLE;
                                standby_next = 1'b1;
                            end
                        end
                    end
                end
                ST_DEVACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_next = BIT_CNT_RESET;
                        if (sda_oe_n_reg)
                        begin
                            sda_oe_n_next = 1'b0;
                        end
                        else if (rw_reg)
                        begin
                            state_next = ST_RDATA;
                            shift_next = rd_byte;
                            sda_oe_n_next = rd_byte[7];
                        end
                        else
                        begin
                            state_next = ST_ADDR;
                            sda_oe_n_next = 1'b1;
                        end
                    end
                end
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_next = rx_byte;
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                        if (last_bit)
                        begin
                            addr_next = rx_addr;
                            state_next = ST_ADDRACK;
                        end
                    end
                end
                ST_ADDRACK:
                begin
                    if (scl_fall)
                    begin
                        if (sda_oe_n_reg)
                        begin
                            sda_oe_n_next = 1'b0;
                        end
                        else
                        begin
                            sda_oe_n_next = 1'b1;
                            state_next = ST_WAIT;
                        end
                    end
                end
                ST_WAIT:
                begin
                    // Data bytes belong to the write engine
                    sda_oe_n_next = 1'b1;
                end
                ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                        if (last_bit)
                        begin
                            sda_oe_n_next = 1'b1;
                            state_next = ST_MACK;
                            addr_next = addr_inc;
                        end
                        else
                        begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            sda_oe_n_next = shift_reg[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        if (!sda_s)
                        begin
                            state_next = ST_NEXT;
                        end
                        else
                        begin
                            state_next = ST_IDLE;
                            standby_next = 1'b1;
                        end
                    end
                end
                ST_NEXT:
                begin
                    if (scl_fall)
                    begin
                        state_next = ST_RDATA;
                        bit_cnt_next = BIT_CNT_RESET;
                        shift_next = rd_byte;
                        sda_oe_n_next = rd_byte[7];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            state_reg <= ST_IDLE;
            bit_cnt_reg <= BIT_CNT_RESET;
            shift_reg <= SHIFT_RESET;
            addr_reg <= ADDR_RESET[ADDR_W-1:0];
            sda_oe_n_reg <= 1'b1;
            standby_reg <= 1'b1;
            rw_reg <= 1'b0;
            sda_lo_reg <= 1'b0;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            addr_reg <= addr_next;
            sda_oe_n_reg <= sda_oe_n_next;
            standby_reg <= standby_next;
            rw_reg <= rw_next;
            sda_lo_reg <= 1'b0;
        end
    end

    assign sda_out = sda_lo_reg;
    assign sda_oe_n_out = sda_oe_n_reg;
    assign standby_out = standby_reg;
    assign addr_out = addr_reg;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (srst_in);

    a_busy_no_ack: assert property (
        (state_reg == ST_DEVSEL && scl_rise && last_bit && prog_busy_in)
        |=> (state_reg == ST_IDLE && sda_oe_n_reg) [*2])
        else $error("select acknowledged while busy");

    a_ready_sel_ack: assert property (
        (state_reg == ST_DEVSEL && scl_rise && last_bit && sel_match && !prog_busy_in
         && !start_evt)
        |=> state_reg == ST_DEVACK && rw_reg == $past(sda_s))
        else $error("ready device failed to take select byte");

    a_ce_mismatch: assert property (
        (state_reg == ST_DEVSEL && scl_rise && last_bit && !ce_ok)
        |=> standby_reg && state_reg == ST_IDLE)
        else $error("mismatched chip enable not deselected");

    a_ack_driven: assert property (
        (state_reg == ST_DEVACK && scl_fall && sda_oe_n_reg && !start_evt)
        |=> !sda_oe_n_reg && state_reg == ST_DEVACK)
        else $error("select acknowledge not driven");

    a_addr_load: assert property (
        (state_reg == ST_ADDR && scl_rise && last_bit && !start_evt && !stop_evt)
        |=> addr_reg == $past(rx_addr))
        else $error("address byte not loaded into counter");

    a_read_first: assert property (
        (state_reg == ST_DEVACK && scl_fall && !sda_oe_n_reg && rw_reg)
        |=> state_reg == ST_RDATA && shift_reg == $past(rd_byte)
            && sda_oe_n_reg == shift_reg[7])
        else $error("read data not started from counter address");

    a_addr_incr: assert property (
        (state_reg == ST_RDATA && scl_fall && last_bit)
        |=> addr_reg == $past(addr_inc) && state_reg == ST_MACK)
        else $error("counter did not advance after byte");

    a_addr_wrap: assert property (
        (state_reg == ST_RDATA && scl_fall && last_bit && addr_reg == addr_top)
        |=> addr_reg == '0)
        else $error("counter did not wrap to zero");

    a_mack_next: assert property (
        (state_reg == ST_MACK && scl_rise && !sda_s && !start_evt)
        |=> state_reg == ST_NEXT ##1 (state_reg == ST_NEXT || state_reg == ST_RDATA))
        else $error("master acknowledge did not request next byte");

    a_nack_stop: assert property (
        (state_reg == ST_MACK && scl_rise && sda_s && !start_evt)
        |=> standby_reg && sda_oe_n_reg && state_reg == ST_IDLE)
        else $error("no acknowledge did not end read");

    a_ack_release: assert property (
        (state_reg == ST_MACK || state_reg == ST_NEXT) |-> sda_oe_n_reg)
        else $error("data line held in master acknowledge slot");

    a_stop_in_read: assert property (
        (state_reg == ST_RDATA && stop_evt && !start_evt)
        |=> !standby_reg && state_reg == ST_RDATA)
        else $error("stop during acknowledged read forced standby");

endmodule // sep_ee_core

// File: src/sep_sync.sv
`timescale 1ns/1ns
module sep_sync
    import sep_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;

endmodule // sep_sync

// File: verification/sep_bus_master.sv
`timescale 1ns/1ns
module sep_bus_master
(
    input wire logic lnk_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    localparam int HALF = 12;

    // Bus idles released, clock high and still
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge lnk_clk_in);
    endtask

    task automatic start();
        sda_low_out = 1'b0;
        tick(HALF);
        scl_out = 1'b1;
        tick(HALF);
        sda_low_out = 1'b1;
        tick(HALF);
        scl_out = 1'b0;
        tick(HALF);
    endtask

    task automatic stop();
        sda_low_out = 1'b1;
        tick(HALF);
        scl_out = 1'b1;
        tick(HALF);
        sda_low_out = 1'b0;
        tick(HALF);
    endtask

    // One bit time; data changes only while clock is low
    task automatic xfer(input logic b, output logic r);
        sda_low_out = ~b;
        tick(HALF);
        scl_out = 1'b1;
        tick(HALF / 2);
        r = sda_in;
        tick(HALF / 2);
        scl_out = 1'b0;
        tick(HALF);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer(d[i], r);
        xfer(1'b1, r);
        ack = ~r;
    endtask

    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer(1'b1, d[i]);
        xfer(~mack, r);
    endtask
endmodule // sep_bus_master

// File: verification/testbench.sv
`timescale 1ns/1ns
module testbench
    import sep_pkg::*;
;
    localparam logic [6:0] SEL = {4'h5, 3'h5};
    logic sys_clk = 1'b0;
    logic lnk_clk = 1'b0;
    logic srst = 1'b1;
    logic prog_busy = 1'b0;
    logic wp = 1'b0;
    logic wr_en = 1'b0;
    logic [MEM_AW-1:0] wr_addr = '0;
    logic [7:0] wr_data = 8'h00;
    logic [2:0] ce = 3'h5;
    logic scl;
    logic sda_low;
    logic sda_do;
    logic sda_oe_n;
    logic standby;
    logic [MEM_AW-1:0] addr;
    wire sda_line = ~sda_low & (sda_oe_n | sda_do);
    int errors = 0;
    int cmp_count = 0;

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        #7;
        forever #32 lnk_clk = ~lnk_clk;
    end

    sep_ee_core sep_ee_core_inst (
        .sys_clk_in(sys_clk), .srst_in(srst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_do), .sda_oe_n_out(sda_oe_n), .chip_sel_pin_0(ce[0]),
        .chip_sel_pin_1(ce[1]), .chip_sel_pin_2(ce[2]), .write_protect_in(wp),
        .prog_busy_in(prog_busy), .mem_wr_en_in(wr_en), .mem_wr_addr_in(wr_addr),
        .mem_wr_data_in(wr_data), .standby_out(standby), .addr_out(addr)
    );

    sep_bus_master sep_bus_master_inst (
        .lnk_clk_in(lnk_clk), .sda_in(sda_line), .scl_out(scl), .sda_low_out(sda_low)
    );

    function automatic logic [7:0] pat(input int a);
        return 8'(a) ^ 8'hA5;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic t_poll();
        logic ack;
        logic [7:0] d;
        @(negedge sys_clk) prog_busy = 1'b1;
        sep_bus_master_inst.start();
        sep_bus_master_inst.wr_byte({SEL, 1'b0}, ack);
        chk({7'h0, ack}, 8'h00);
        sep_bus_master_inst.stop();
        chk({7'h0, standby}, 8'h01);
        @(negedge sys_clk) prog_busy = 1'b0;
        // Programming starts after the start condition was taken
        sep_bus_master_inst.start();
        @(negedge sys_clk) prog_busy = 1'b1;
        sep_bus_master_inst.wr_byte({SEL, 1'b0}, ack);
        chk({7'h0, ack}, 8'h00);
        chk({7'h0, standby}, 8'h01);
        sep_bus_master_inst.stop();
        @(negedge sys_clk) prog_busy = 1'b0;
        sep_bus_master_inst.start();
        sep_bus_master_inst.wr_byte({SEL, 1'b0}, ack);
        chk({7'h0, ack}, 8'h01);
        sep_bus_master_inst.wr_byte(8'hFE, ack);
        chk({7'h0, ack}, 8'h01);
        chk(addr, 8'hFE);
        sep_bus_master_inst.start();
        sep_bus_master_inst.wr_byte({SEL, 1'b1}, ack);
        chk({7'h0, ack}, 8'h01);
        sep_bus_master_inst.rd_byte(1'b1, d);
        chk(d, pat(8'hFE));
        chk(addr, 8'hFF);
        sep_bus_master_inst.rd_byte(1'b1, d);
        chk(d, pat(8'hFF));
        chk(addr, 8'h00);
        sep_bus_master_inst.rd_byte(1'b0, d);
        chk(d, pat(8'h00));
        chk({7'h0, standby}, 8'h01);
        sep_bus_master_inst.stop();
    endtask

    task automatic t_current();
        logic ack;
        logic [7:0] d;
        @(negedge sys_clk) wp = 1'b1;
        sep_bus_master_inst.start();
        sep_bus_master_inst.wr_byte({SEL, 1'b1}, ack);
        chk({7'h0, ack}, 8'h01);
        sep_bus_master_inst.rd_byte(1'b1, d);
        chk(d, pat(8'h01));
        chk(addr, 8'h02);
        // Stop after an acknowledged byte leaves the read running
        sep_bus_master_inst.stop();
        chk({7'h0, standby}, 8'h00);
        @(negedge sys_clk) wp = 1'b0;
    endtask

    task automatic t_mismatch();
        logic ack;
        logic [7:0] bad [2] = '{{4'h5, 3'h2, 1'b1}, {4'hC, 3'h5, 1'b1}};
        for (int i = 0; i < 2; i++)
        begin
            sep_bus_master_inst.start();
            sep_bus_master_inst.wr_byte(bad[i], ack);
            chk({7'h0, ack}, 8'h00);
            chk({7'h0, standby}, 8'h01);
            sep_bus_master_inst.stop();
        end
    endtask

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        errors++;
        final_report();
    end

    initial
    begin
        repeat (16) @(negedge sys_clk);
        chk({7'h0, standby}, 8'h01);
        chk(addr, 8'h00);
        chk({7'h0, sda_oe_n}, 8'h01);
        srst = 1'b0;
        for (int a = 0; a < 256; a++)
        begin
            @(negedge sys_clk);
            wr_en = 1'b1;
            wr_addr = 8'(a);
            wr_data = pat(a);
        end
        @(negedge sys_clk) wr_en = 1'b0;
        repeat (8) @(negedge sys_clk);
        t_poll();
        t_current();
        t_mismatch();
        final_report();
    end
endmodule // testbench
